// File: design/input_only_port_pin.v
// Input-only port pin with master-clear function and AXI4-Lite registers
// What this block does
// - The pin is input only, with no output driver and no output priority selection.
// - The pin acts as master-clear reset input unless the configuration fuse disables it.
// - The direction bit is unimplemented, always reads one and ignores writes.
// - Bit 3 of the level register returns the synchronised pin level; every reset loads the synchroniser with one.
// - Bits 7-4 and 2-0 of level, pull-up and threshold registers read zero.
// - Threshold bit selects Schmitt when one, TTL when zero, resets to one, feeds reads and change detect.
// - Pull-up bit enables the weak pull-up when one, is read/write and resets to one.
// - Individual pull-up acts only while the global pull-up disable bit is clear.
`include "input_pin_defines.vh"
module input_only_port_pin (
  input wire CLK,
  input wire NRST,
  input wire PIN_ST,
  input wire PIN_TTL,
  input wire MASTER_CLEAR_INPUT_FUSE_EN,
  output reg PULLUP_ON,
  output reg MASTER_CLEAR_REQ,
  output reg PIN_LEVEL,
  output reg PIN_CHANGE,
  input wire [7:0] S_AXI_AWADDR,
  input wire S_AXI_AWVALID,
  output reg S_AXI_AWREADY,
  input wire [31:0] S_AXI_WDATA,
  input wire [3:0] S_AXI_WSTRB,
  input wire S_AXI_WVALID,
  output reg S_AXI_WREADY,
  output reg [1:0] S_AXI_BRESP,
  output reg S_AXI_BVALID,
  input wire S_AXI_BREADY,
  input wire [7:0] S_AXI_ARADDR,
  input wire S_AXI_ARVALID,
  output reg S_AXI_ARREADY,
  output reg [31:0] S_AXI_RDATA,
  output reg [1:0] S_AXI_RRESP,
  output reg S_AXI_RVALID,
  input wire S_AXI_RREADY
);
  reg pin_pullup_bit_q;
  reg pin_threshold_bit_q;
  reg global_pullup_disable_q;
  reg aw_have_q;
  reg w_have_q;
  reg [7:0] aw_addr_q;
  reg [31:0] w_data_q;
  reg w_lane0_q;
  reg level_prev_q;
  wire input_pin_level;
  wire do_write;
  wire wr_pullup;
  wire wr_thresh;
  wire wr_config;
  reg [7:0] rd_byte;
  wire rd_hit;

  // Register value placed at the pin bit, other bits zero
  function [7:0] pin_field;
    input b;
    begin
      pin_field = 8'h00;
      pin_field[`PIN_BIT] = b;
    end
  endfunction

  function is_mapped;
    input [7:0] a;
    begin
      is_mapped = (a == `OFS_LEVEL) || (a == `OFS_DIR) || (a == `OFS_PULLUP) ||
                  (a == `OFS_THRESH) || (a == `OFS_CONFIG);
    end
  endfunction

  pin_input_stage u_stage (
    .clk(CLK),
    .nrst(NRST),
    .pin_st(PIN_ST),
    .pin_ttl(PIN_TTL),
    .thresh_sel(pin_threshold_bit_q),
    .level(input_pin_level)
  );

  assign do_write = aw_have_q && w_have_q && !S_AXI_BVALID;

  // Byte lane 0 carries every implemented bit
  assign wr_pullup = do_write && w_lane0_q && (aw_addr_q == `OFS_PULLUP);
  assign wr_thresh = do_write && w_lane0_q && (aw_addr_q == `OFS_THRESH);
  assign wr_config = do_write && w_lane0_q && (aw_addr_q == `OFS_CONFIG);

  // Write address, held until the response is taken
  always @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      aw_have_q <= 1'b0;
      aw_addr_q <= 8'h00;
      S_AXI_AWREADY <= 1'b1;
    end else begin
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
        aw_have_q <= 1'b1;
        aw_addr_q <= S_AXI_AWADDR;
        S_AXI_AWREADY <= 1'b0;
      end
      if (do_write) begin
        aw_have_q <= 1'b0;
      end
      if (S_AXI_BVALID && S_AXI_BREADY) begin
        S_AXI_AWREADY <= 1'b1;
      end
    end
  end

  // Write data, taken before or after the address
  always @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      w_have_q <= 1'b0;
      w_data_q <= 32'h0000_0000;
      w_lane0_q <= 1'b0;
      S_AXI_WREADY <= 1'b1;
    end else begin
      if (S_AXI_WVALID && S_AXI_WREADY) begin
        w_have_q <= 1'b1;
        w_data_q <= S_AXI_WDATA;
        w_lane0_q <= S_AXI_WSTRB[0];
        S_AXI_WREADY <= 1'b0;
      end
      if (do_write) begin
        w_have_q <= 1'b0;
      end
      if (S_AXI_BVALID && S_AXI_BREADY) begin
        S_AXI_WREADY <= 1'b1;
      end
    end
  end

  // Write response once both halves are in
  always @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP <= `RESP_OKAY;
    end else if (do_write) begin
      S_AXI_BVALID <= 1'b1;
      S_AXI_BRESP <= is_mapped(aw_addr_q) ? `RESP_OKAY : `RESP_SLVERR;
    end else if (S_AXI_BVALID && S_AXI_BREADY) begin
      S_AXI_BVALID <= 1'b0;
    end
  end

  // Writable control bits; direction and level registers ignore writes
  always @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      pin_pullup_bit_q <= `RST_PULLUP;
      pin_threshold_bit_q <= `RST_THRESH;
      global_pullup_disable_q <= `RST_GLOBAL_PU;
    end else begin
      if (wr_pullup) begin
        pin_pullup_bit_q <= w_data_q[`PIN_BIT];
      end
      if (wr_thresh) begin
        pin_threshold_bit_q <= w_data_q[`PIN_BIT];
      end
      if (wr_config) begin
        global_pullup_disable_q <= w_data_q[`CFG_GLOBAL_PU_BIT];
      end
    end
  end

  // level bit; direction reads one; config bits 1-0 return fuse and global pull-up disable; other bits zero
  always @* begin
    case (S_AXI_ARADDR)
      `OFS_LEVEL: rd_byte = pin_field(input_pin_level);
      `OFS_DIR: rd_byte = pin_field(1'b1);
      `OFS_PULLUP: rd_byte = pin_field(pin_pullup_bit_q);
      `OFS_THRESH: rd_byte = pin_field(pin_threshold_bit_q);
      `OFS_CONFIG: rd_byte = {6'b00_0000, MASTER_CLEAR_INPUT_FUSE_EN, global_pullup_disable_q};
      default: rd_byte = 8'h00;
    endcase
  end
  assign rd_hit = is_mapped(S_AXI_ARADDR);

  always @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      S_AXI_ARREADY <= 1'b1;
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA <= 32'h0000_0000;
      S_AXI_RRESP <= `RESP_OKAY;
    end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID <= 1'b1;
      S_AXI_RDATA <= {24'h00_0000, rd_byte};
      S_AXI_RRESP <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
    end else if (S_AXI_RVALID && S_AXI_RREADY) begin
      S_AXI_RVALID <= 1'b0;
      S_AXI_ARREADY <= 1'b1;
    end
  end

  // no output driver; only the pull-up faces the pad
  always @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      PULLUP_ON <= 1'b0;
      MASTER_CLEAR_REQ <= 1'b0;
    end else begin
      PULLUP_ON <= pin_pullup_bit_q && !global_pullup_disable_q;
      MASTER_CLEAR_REQ <= MASTER_CLEAR_INPUT_FUSE_EN && !input_pin_level;
    end
  end

  // Level and change pulse; idle-high reset avoids a false edge
  always @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      PIN_LEVEL <= `RST_PIN_IDLE;
      PIN_CHANGE <= 1'b0;
      level_prev_q <= `RST_PIN_IDLE;
    end else begin
      PIN_LEVEL <= input_pin_level;
      level_prev_q <= input_pin_level;
      PIN_CHANGE <= input_pin_level ^ level_prev_q;
    end
  end
endmodule

// File: design/input_pin_defines.vh
// Register map, field positions, reset values for the input-only port pin
`ifndef INPUT_PIN_DEFINES_VH
`define INPUT_PIN_DEFINES_VH
`define OFS_LEVEL 8'h00
`define OFS_DIR 8'h04
`define OFS_PULLUP 8'h08
`define OFS_THRESH 8'h0C
`define OFS_CONFIG 8'h10
`define PIN_BIT 3
`define CFG_GLOBAL_PU_BIT 0
`define CFG_MASTER_CLEAR_INPUT_EN_BIT 1
`define RST_PULLUP 1'b1
`define RST_THRESH 1'b1
`define RST_GLOBAL_PU 1'b0
`define RST_MASTER_CLEAR_INPUT_EN 1'b1
`define RST_PIN_IDLE 1'b1
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10
`endif

// File: design/pin_input_stage.v
// Input threshold select and two-flop synchroniser for the pin
`include "input_pin_defines.vh"
module pin_input_stage (
  input wire clk,
  input wire nrst,
  input wire pin_st,
  input wire pin_ttl,
  input wire thresh_sel,
  output wire level
);
  reg meta_q;
  reg sync_q;
  wire chosen;
  assign chosen = thresh_sel ? pin_st : pin_ttl;
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      // Pin idles high with the pull-up on: no false low after reset
      meta_q <= `RST_PIN_IDLE;
      sync_q <= `RST_PIN_IDLE;
    end else begin
      meta_q <= chosen;
      sync_q <= meta_q;
    end
  end
  assign level = sync_q;
endmodule

// File: dv/pin_port_checker_properties.sv
// Port-level assertions for the input-only port pin
module pin_port_checker (
  input wire CLK,
  input wire NRST,
  input wire PIN_ST,
  input wire PIN_TTL,
  input wire MASTER_CLEAR_INPUT_FUSE_EN,
  input wire PULLUP_ON,
  input wire MASTER_CLEAR_REQ,
  input wire PIN_LEVEL,
  input wire S_AXI_AWREADY,
  input wire S_AXI_BVALID,
  input wire [7:0] S_AXI_ARADDR,
  input wire S_AXI_ARVALID,
  input wire S_AXI_ARREADY,
  input wire [31:0] S_AXI_RDATA,
  input wire S_AXI_RVALID
);
  default clocking @(posedge CLK);
  endclocking
  default disable iff (!NRST);
  AST_FUSE_OFF: assert property (!MASTER_CLEAR_INPUT_FUSE_EN |=> !MASTER_CLEAR_REQ)
    else $error("clear request with fuse off");
  AST_DIR_ONE: assert property (S_AXI_ARVALID && S_AXI_ARREADY && S_AXI_ARADDR == 8'h04
    |=> S_AXI_RDATA == 32'h0000_0008)
    else $error("direction not input");
  AST_ZERO_BITS: assert property (S_AXI_RVALID |-> S_AXI_RDATA[31:4] == 0 && !S_AXI_RDATA[2])
    else $error("unused bits set");
  AST_LEVEL: assert property ((PIN_ST == PIN_TTL && $stable(PIN_ST))[*4] |-> PIN_LEVEL == PIN_ST)
    else $error("level not following pin");
  AST_PU_RESET: assert property ($rose(NRST) |=> PULLUP_ON)
    else $error("pull-up off after reset");
  AST_RD_LAT: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
    else $error("read answer late");
  AST_AR_BUSY: assert property (S_AXI_RVALID |-> !S_AXI_ARREADY)
    else $error("read taken while busy");
  AST_AW_BUSY: assert property (S_AXI_BVALID |-> !S_AXI_AWREADY)
    else $error("write taken while busy");
endmodule
bind input_only_port_pin pin_port_checker props (.CLK, .NRST, .PIN_ST, .PIN_TTL, .MASTER_CLEAR_INPUT_FUSE_EN, .PULLUP_ON,
  .MASTER_CLEAR_REQ, .PIN_LEVEL, .S_AXI_AWREADY, .S_AXI_BVALID, .S_AXI_ARADDR, .S_AXI_ARVALID,
  .S_AXI_ARREADY, .S_AXI_RDATA, .S_AXI_RVALID);

// File: dv/test_input_only_port_pin.sv
// Register and pin tests for the input-only port pin
module test_input_only_port_pin;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, nrst = 0, st = 1, ttl = 1, fuse = 1, awv = 0, wv = 0, bry = 0, arv = 0, rry = 0;
  logic [7:0] awa = 0, ara = 0;
  logic [31:0] wd = 0, rd;
  logic [3:0] ws = 4'hF;
  logic awr, wrd, bv, arr, rv, pu, mcr, lvl, chg;
  logic [1:0] br, rr, resp;
  int miscompares = 0, cmp_count = 0, n;
  always #5 clk = ~clk;
  input_only_port_pin dut (.CLK(clk), .NRST(nrst), .PIN_ST(st), .PIN_TTL(ttl), .MASTER_CLEAR_INPUT_FUSE_EN(fuse),
    .PULLUP_ON(pu), .MASTER_CLEAR_REQ(mcr), .PIN_LEVEL(lvl), .PIN_CHANGE(chg), .S_AXI_AWADDR(awa),
    .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr), .S_AXI_WDATA(wd), .S_AXI_WSTRB(ws), .S_AXI_WVALID(wv),
    .S_AXI_WREADY(wrd), .S_AXI_BRESP(br), .S_AXI_BVALID(bv), .S_AXI_BREADY(bry), .S_AXI_ARADDR(ara),
    .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr), .S_AXI_RDATA(rd), .S_AXI_RRESP(rr), .S_AXI_RVALID(rv),
    .S_AXI_RREADY(rry));
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      miscompares++;
      $display("wrong value %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic complete_run;
    if (miscompares == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic tmo;
    if (n == 40) begin
      miscompares++;
      complete_run;
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    awa <= a;
    wd <= d;
    awv <= 1;
    wv <= 1;
    bry <= 1;
    for (n = 0; n < 40; n++) begin
      @(posedge clk);
      if (awr) awv <= 0;
      if (wrd) wv <= 0;
      if (bv) begin
        resp = br;
        bry <= 0;
        break;
      end
    end
    @(posedge clk);
    tmo;
  endtask
  task automatic rdr(input logic [7:0] a, input logic [31:0] e);
    ara <= a;
    arv <= 1;
    rry <= 1;
    for (n = 0; n < 40; n++) begin
      @(posedge clk);
      if (arr) arv <= 0;
      if (rv) begin
        resp = rr;
        rry <= 0;
        chk("rdata", e, rd);
        break;
      end
    end
    @(posedge clk);
    tmo;
  endtask
  initial begin
    repeat (6) @(posedge clk);
    nrst <= 1;
    repeat (2) @(posedge clk);
    chk("pullup", 1'h1, pu);
    chk("master_clear_input", 1'h0, mcr);
    chk("change", 1'h0, chg);
    rdr(8'h00, 32'h0000_0008);
    chk("level", 1'h1, lvl);
    rdr(8'h0C, 32'h0000_0008);
    rdr(8'h10, 32'h0000_0002);
    wr(8'h04, 32'h0000_0000);
    chk("bresp", 32'h0000_0000, resp);
    rdr(8'h04, 32'h0000_0008);
    wr(8'h08, 32'hFFFF_FFFF);
    rdr(8'h08, 32'h0000_0008);
    wr(8'h08, 32'h0000_0000);
    rdr(8'h08, 32'h0000_0000);
    chk("pullup", 1'h0, pu);
    wr(8'h08, 32'h0000_0008);
    chk("pullup", 1'h1, pu);
    ws <= 4'h0;
    wr(8'h08, 32'h0000_0000);
    ws <= 4'hF;
    rdr(8'h08, 32'h0000_0008);
    wr(8'h10, 32'h0000_0001);
    @(posedge clk);
    chk("pullup", 1'h0, pu);
    st <= 0;
    repeat (3) @(posedge clk);
    chk("change", 1'h0, chg);
    @(posedge clk);
    chk("change", 1'h1, chg);
    @(posedge clk);
    chk("change", 1'h0, chg);
    chk("level", 1'h0, lvl);
    rdr(8'h00, 32'h0000_0000);
    chk("master_clear_input", 1'h1, mcr);
    wr(8'h0C, 32'h0000_0000);
    repeat (4) @(posedge clk);
    rdr(8'h00, 32'h0000_0008);
    chk("level", 1'h1, lvl);
    fuse <= 0;
    wr(8'h0C, 32'h0000_0008);
    repeat (4) @(posedge clk);
    chk("master_clear_input", 1'h0, mcr);
    rdr(8'h20, 32'h0000_0000);
    chk("resp", 32'h0000_0002, resp);
    wr(8'h20, 32'h0000_0008);
    chk("bresp", 32'h0000_0002, resp);
    ttl <= 0;
    repeat (4) @(posedge clk);
    chk("level", 1'h0, lvl);
    wr(8'h08, 32'h0000_0000);
    wr(8'h0C, 32'h0000_0000);
    st <= 1;
    ttl <= 1;
    nrst <= 0;
    repeat (2) @(posedge clk);
    nrst <= 1;
    repeat (2) @(posedge clk);
    chk("pullup", 1'h1, pu);
    rdr(8'h08, 32'h0000_0008);
    rdr(8'h0C, 32'h0000_0008);
    rdr(8'h10, 32'h0000_0000);
    complete_run;
  end
endmodule
